//--- include/audio_ctl_pkg.sv
/*
 * Shared constants, types and the volume decoder for the two-wire audio
 * control link: the slave end (audio processor) and the master end.
 * Assumes a single 100 MHz clock in both ends.
 */
`default_nettype none
package audio_ctl_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_HZ         = 100_000_000;
	localparam int MAX_BIT_HZ     = 100_000;
	// Quarter of a bit period, rounded up so the bit rate never exceeds the limit
	localparam int QUARTER_CYCLES = (CLK_HZ + 4 * MAX_BIT_HZ - 1) / (4 * MAX_BIT_HZ);

	// ==========================================================
	// Link framing
	localparam logic [7:0] ADDR_PIN_OPEN = 8'h32;
	localparam logic [7:0] ADDR_PIN_GND  = 8'h30;
	localparam logic [3:0] LAST_BIT      = 4'h8;
	localparam logic [3:0] ACK_BIT       = 4'h8;
	localparam logic [7:0] POR_CODE      = 8'hfe;

	// ==========================================================
	// Function byte layout
	localparam int         FUNC_HI        = 7;
	localparam int         FUNC_LO        = 5;
	localparam logic [2:0] FUNC_MUTE      = 3'h4;
	localparam logic [2:0] FUNC_INPUT     = 3'h5;
	localparam logic [2:0] FUNC_CHAN      = 3'h6;
	localparam int         VOL_HI         = 6;
	localparam int         COARSE_LO      = 3;
	localparam int         FINE_HI        = 2;
	localparam int         MUTE_A_BIT     = 6;
	localparam int         MUTE_B_BIT     = 5;
	localparam int         SMUTE_FAST_BIT = 0;
	localparam int         SMUTE_OFF_BIT  = 1;
	localparam int         LOUD_OFF_BIT   = 2;
	localparam int         LOUD_20_BIT    = 3;
	localparam int         SEL_HI         = 1;
	localparam logic [1:0] SRC_MUTE       = 2'h0;
	localparam logic [1:0] SRC_B          = 2'h1;
	localparam logic [1:0] SRC_C          = 2'h2;
	localparam logic [1:0] SRC_A          = 2'h3;
	localparam logic [1:0] CH_RIGHT       = 2'h0;
	localparam logic [1:0] CH_LEFT        = 2'h1;
	localparam int         ATT_W          = 7;

	// ==========================================================
	// Master register map (AXI4-Lite)
	localparam int          AXI_ADDR_W    = 4;
	localparam logic [3:0]  REG_CMD       = 4'h0;
	localparam logic [3:0]  REG_STATUS    = 4'h4;
	localparam logic [3:0]  REG_CTRL      = 4'h8;
	localparam int          CMD_START_BIT = 8;
	localparam int          CMD_STOP_BIT  = 9;
	localparam int          ST_BUSY       = 0;
	localparam int          ST_NACK       = 1;
	localparam int          ST_ABORT      = 2;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ==========================================================
	// State types
	typedef enum logic [1:0] {
		D_IDLE = 2'b00, D_ADDR = 2'b01, D_DATA = 2'b11, D_SKIP = 2'b10
	} dev_state_type;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00, H_START = 2'b01, H_BITS = 2'b11, H_STOP = 2'b10
	} host_state_type;

	// Volume code to {mute, attenuation in dB}
	function automatic logic [ATT_W:0] vol_decode(input logic [VOL_HI:0] c);
		logic [ATT_W-1:0] att;
		att = {c[VOL_HI:COARSE_LO], 3'h0} + {4'h0, c[FINE_HI:0]};
		return {c[MUTE_A_BIT] & c[MUTE_B_BIT], att};
	endfunction
endpackage
`default_nettype wire

//--- include/two_wire_if.sv
/*
 * Two-wire open-drain link between the master end and the audio processor.
 * Assumes pull-ups: a wire reads low only while some end enables a low drive.
 */
`default_nettype none
interface two_wire_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND resolution with pull-up
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

	modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
	modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface
`default_nettype wire

//--- logic/audio_ctl_device.sv
/*
 * Audio processor control end: two-wire slave that decodes function bytes
 * into volume, mute, loudness, input and channel settings.
 * Assumes the link wires are asynchronous and slow against aclk.
 */
// How it works
// - Data sampled only on clock rise
// - Data fall with clock high starts
// - Data rise with clock high stops
// - Eight bits MSB first, then ack
// - Master releases data during ack
// - Slave holds data low whole ack
// - Master may stop after a nack
// - Master may skip checking ack
// - Start, address, data bytes, stop
// - Address follows the select pin
// - Bit rate at most 100 kbit/s
// - Top bits classify each function byte
// - Soft mute off, slow or fast
// - Loudness off, 10 or 20 dB
// - Reset state decodes pattern 11111110
`default_nettype none
module audio_ctl_device (
	input  wire logic                            aclk,
	input  wire logic                            aresetn,
	two_wire_if.dev                              link,
	input  wire logic                            addr_pin_open,
	output logic [audio_ctl_pkg::ATT_W-1:0]      att_left,
	output logic                                 mute_left,
	output logic [audio_ctl_pkg::ATT_W-1:0]      att_right,
	output logic                                 mute_right,
	output logic                                 soft_mute_on,
	output logic                                 soft_mute_fast,
	output logic                                 loud_on,
	output logic                                 loud_20db,
	output logic                                 source_input_a,
	output logic                                 source_input_b,
	output logic                                 source_input_c,
	output logic                                 chan_left_en,
	output logic                                 chan_right_en
);
	import audio_ctl_pkg::*;

	// ==========================================================
	// Reset values from the power-on pattern
	localparam logic [ATT_W:0] RST_VOL = vol_decode(POR_CODE[VOL_HI:0]);
	localparam logic [1:0]     RST_SEL = POR_CODE[SEL_HI:0];

	// ==========================================================
	// Pin synchronisation and bus conditions
	logic [2:0] pins_sync;
	logic       scl_reg;
	logic       sda_reg;

	sync2 #(.WIDTH(3)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     ({link.scl, link.sda, addr_pin_open}),
		.dout    (pins_sync)
	);

	wire scl_now   = pins_sync[2];
	wire sda_now   = pins_sync[1];
	wire addr_open = pins_sync[0];

	// Previous levels for edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end else begin
			scl_reg <= scl_now;
			sda_reg <= sda_now;
		end
	end

	// Edges and framing conditions
	wire scl_rise   = scl_now & ~scl_reg;
	wire scl_fall   = ~scl_now & scl_reg;
	wire start_seen = scl_now & scl_reg & sda_reg & ~sda_now;
	wire stop_seen  = scl_now & scl_reg & ~sda_reg & sda_now;

	// ==========================================================
	// Byte receiver
	dev_state_type state_reg;
	dev_state_type state_next;
	logic [3:0]    bit_cnt_reg;
	logic [3:0]    bit_cnt_next;
	logic [7:0]    shift_reg;
	logic [7:0]    shift_next;
	logic          ack_slot_reg;
	logic          ack_slot_next;
	logic          sda_oe_reg;
	logic          sda_oe_next;

	wire [7:0] own_addr = addr_open ? ADDR_PIN_OPEN : ADDR_PIN_GND;
	wire       addr_hit = (shift_reg == own_addr);
	wire       in_byte  = (state_reg == D_ADDR) || (state_reg == D_DATA);
	wire       byte_done = in_byte & scl_fall & (bit_cnt_reg == LAST_BIT) & ~ack_slot_reg;
	wire       ack_done = in_byte & scl_fall & ack_slot_reg;

	// Receiver next state
	always_comb begin
		state_next    = state_reg;
		bit_cnt_next  = bit_cnt_reg;
		shift_next    = shift_reg;
		ack_slot_next = ack_slot_reg;
		sda_oe_next   = sda_oe_reg;
		if (start_seen) begin
			state_next    = D_ADDR;
			bit_cnt_next  = 4'h0;
			ack_slot_next = 1'b0;
			sda_oe_next   = 1'b0;
		end else if (stop_seen) begin
			state_next    = D_IDLE;
			bit_cnt_next  = 4'h0;
			ack_slot_next = 1'b0;
			sda_oe_next   = 1'b0;
		end else if (in_byte) begin
			if (scl_rise && bit_cnt_reg != LAST_BIT) begin
				shift_next   = {shift_reg[6:0], sda_now};
				bit_cnt_next = bit_cnt_reg + 4'h1;
			end
			if (byte_done) begin
				ack_slot_next = 1'b1;
				sda_oe_next   = (state_reg == D_DATA) | addr_hit;
				if (state_reg == D_ADDR) begin
					state_next = addr_hit ? D_DATA : D_SKIP;
				end
			end
			if (ack_done) begin
				ack_slot_next = 1'b0;
				sda_oe_next   = 1'b0;
				bit_cnt_next  = 4'h0;
			end
		end
	end

	// Receiver registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg    <= D_IDLE;
			bit_cnt_reg  <= 4'h0;
			shift_reg    <= 8'h00;
			ack_slot_reg <= 1'b0;
			sda_oe_reg   <= 1'b0;
		end else begin
			state_reg    <= state_next;
			bit_cnt_reg  <= bit_cnt_next;
			shift_reg    <= shift_next;
			ack_slot_reg <= ack_slot_next;
			sda_oe_reg   <= sda_oe_next;
		end
	end

	// Open-drain data: low only while acknowledging
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = sda_oe_reg;

	// ==========================================================
	// Function decode
	// skipped transfers never apply
	wire       apply     = byte_done & (state_reg == D_DATA);
	wire [2:0] func      = shift_reg[FUNC_HI:FUNC_LO];
	wire       is_vol    = apply & ~shift_reg[FUNC_HI];
	wire       is_mute   = apply & (func == FUNC_MUTE);
	wire       is_input  = apply & (func == FUNC_INPUT);
	wire       is_chan   = apply & (func == FUNC_CHAN);
	wire [ATT_W:0] vol_new = vol_decode(shift_reg[VOL_HI:0]);
	wire [1:0]     sel     = shift_reg[SEL_HI:0];
	wire       want_left  = (sel != CH_RIGHT);
	wire       want_right = (sel != CH_LEFT);

	// ==========================================================
	// Channel selection and volume
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_left_en           <= (RST_SEL != CH_RIGHT);
			chan_right_en          <= (RST_SEL != CH_LEFT);
			{mute_left, att_left}   <= RST_VOL;
			{mute_right, att_right} <= RST_VOL;
		end else begin
			if (is_chan) begin
				chan_left_en  <= want_left;
				chan_right_en <= want_right;
			end
			if (is_vol && chan_left_en) begin
				{mute_left, att_left} <= vol_new;
			end
			if (is_vol && chan_right_en) begin
				{mute_right, att_right} <= vol_new;
			end
		end
	end

	// ==========================================================
	// Soft mute, loudness and input selector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_mute_on   <= ~POR_CODE[SMUTE_OFF_BIT];
			soft_mute_fast <= POR_CODE[SMUTE_FAST_BIT];
			loud_on        <= ~POR_CODE[LOUD_OFF_BIT];
			loud_20db      <= POR_CODE[LOUD_20_BIT];
			source_input_a <= (RST_SEL == SRC_A);
			source_input_b <= (RST_SEL == SRC_B);
			source_input_c <= (RST_SEL == SRC_C);
		end else begin
			if (is_mute) begin
				soft_mute_on   <= ~shift_reg[SMUTE_OFF_BIT];
				soft_mute_fast <= shift_reg[SMUTE_FAST_BIT];
				loud_on        <= ~shift_reg[LOUD_OFF_BIT];
				loud_20db      <= shift_reg[LOUD_20_BIT];
			end
			if (is_input) begin
				source_input_a <= (sel == SRC_A);
				source_input_b <= (sel == SRC_B);
				source_input_c <= (sel == SRC_C);
			end
		end
	end
endmodule
`default_nettype wire

//--- logic/audio_ctl_host.sv
/*
 * Master end of the audio control link, commanded over AXI4-Lite.
 * Assumes the slave never stretches the clock.
 */
`default_nettype none
module audio_ctl_host #(
	parameter int QUARTER = audio_ctl_pkg::QUARTER_CYCLES
) (
	input  wire logic                                aclk,
	input  wire logic                                aresetn,
	two_wire_if.host                                 link,
	input  wire logic [audio_ctl_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                                s_axi_awvalid,
	output logic                                     s_axi_awready,
	input  wire logic [31:0]                         s_axi_wdata,
	input  wire logic [3:0]                          s_axi_wstrb,
	input  wire logic                                s_axi_wvalid,
	output logic                                     s_axi_wready,
	output logic [1:0]                               s_axi_bresp,
	output logic                                     s_axi_bvalid,
	input  wire logic                                s_axi_bready,
	input  wire logic [audio_ctl_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                                s_axi_arvalid,
	output logic                                     s_axi_arready,
	output logic [31:0]                              s_axi_rdata,
	output logic [1:0]                               s_axi_rresp,
	output logic                                     s_axi_rvalid,
	input  wire logic                                s_axi_rready
);
	import audio_ctl_pkg::*;

	// Sync lag must fit well inside a quarter bit; the divider is 16 bits
	if (QUARTER < 4 || QUARTER > 65536) $error("QUARTER must lie in 4 to 65536");

	// ==========================================================
	// Register slave
	host_state_type state_reg;
	logic [7:0]     byte_reg;
	logic           stop_req_reg;
	logic           check_ack_reg;
	logic           nack_reg;
	logic           abort_reg;
	wire            busy = (state_reg != H_IDLE);

	wire aw_hs    = s_axi_awready & s_axi_awvalid;
	wire ar_hs    = s_axi_arready & s_axi_arvalid;
	wire wr_cmd   = aw_hs & (s_axi_awaddr == REG_CMD);
	wire wr_ctrl  = aw_hs & (s_axi_awaddr == REG_CTRL);
	wire cmd_go   = wr_cmd & ~busy & s_axi_wstrb[0];
	wire wr_bad   = ~(wr_ctrl | (wr_cmd & ~busy));
	wire [31:0] rd_val = (s_axi_araddr == REG_STATUS) ?
		{29'h0, abort_reg, nack_reg, busy} : {31'h0, check_ack_reg};
	wire rd_bad   = (s_axi_araddr != REG_STATUS) && (s_axi_araddr != REG_CTRL);

	// Address/data taken together, one answer at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			check_ack_reg <= 1'b0;
		end else begin
			s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
			if (aw_hs) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_ctrl && s_axi_wstrb[0]) begin
				check_ack_reg <= s_axi_wdata[0];
			end
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (ar_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_bad ? 32'h0 : rd_val;
				s_axi_rresp  <= rd_bad ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Link engine: four quarter-bit phases per step
	logic [15:0] div_reg;
	logic [1:0]  phase_reg;
	logic [3:0]  bit_reg;
	logic        scl_low_reg;
	logic        sda_low_reg;
	logic        sda_in;

	sync2 #(.WIDTH(1)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (link.sda),
		.dout    (sda_in)
	);

	wire tick    = busy & (div_reg == 16'(QUARTER - 1));
	wire last_ph = tick & (phase_reg == 2'h3);
	// MSB first; release in ack slot
	wire tx_bit  = (bit_reg == ACK_BIT) ? 1'b1 : byte_reg[3'(7 - bit_reg)];
	wire ack_bad = sda_in & check_ack_reg;

	// Quarter divider
	always_ff @(posedge aclk) begin
		if (!aresetn || !busy || tick) begin
			div_reg <= 16'h0;
		end else begin
			div_reg <= div_reg + 16'h1;
		end
	end

	// Phase sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg    <= H_IDLE;
			phase_reg    <= 2'h0;
			bit_reg      <= 4'h0;
			byte_reg     <= 8'h0;
			stop_req_reg <= 1'b0;
			scl_low_reg  <= 1'b0;
			sda_low_reg  <= 1'b0;
			nack_reg     <= 1'b0;
			abort_reg    <= 1'b0;
		end else if (cmd_go) begin
			state_reg    <= s_axi_wdata[CMD_START_BIT] ? H_START : H_BITS;
			byte_reg     <= s_axi_wdata[7:0];
			stop_req_reg <= s_axi_wdata[CMD_STOP_BIT];
			phase_reg    <= 2'h0;
			bit_reg      <= 4'h0;
			nack_reg     <= 1'b0;
			abort_reg    <= 1'b0;
		end else if (tick) begin
			phase_reg <= phase_reg + 2'h1;
			// in bits, data moves only in phase 0, clock low
			case (state_reg)
				H_START: begin
					sda_low_reg <= (phase_reg != 2'h0);
					scl_low_reg <= (phase_reg == 2'h3);
					if (last_ph) state_reg <= H_BITS;
				end
				H_BITS: begin
					if (phase_reg == 2'h0) sda_low_reg <= ~tx_bit;
					// Clock low through phases 3 and 0, high across the sample
					scl_low_reg <= (phase_reg == 2'h3) | (phase_reg == 2'h0);
					if (phase_reg == 2'h2 && bit_reg == ACK_BIT && sda_in) nack_reg <= 1'b1;
					if (phase_reg == 2'h2 && bit_reg == ACK_BIT && ack_bad) abort_reg <= 1'b1;
					if (last_ph) begin
						bit_reg <= bit_reg + 4'h1;
						if (bit_reg == ACK_BIT) begin
							state_reg <= (stop_req_reg | abort_reg) ? H_STOP : H_IDLE;
						end
					end
				end
				H_STOP: begin
					// data rises while clock high
					// Data low, clock up, then data up; both left released
					sda_low_reg <= (phase_reg == 2'h0) | (phase_reg == 2'h1);
					scl_low_reg <= (phase_reg == 2'h0);
					if (last_ph) state_reg <= H_IDLE;
				end
				default: begin
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

	// Open-drain pins
	assign link.host_scl_o  = 1'b0;
	assign link.host_scl_oe = scl_low_reg;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = sda_low_reg;
endmodule
`default_nettype wire

//--- logic/sync2.sv
/*
 * Two-flop synchroniser for asynchronous levels.
 * Assumes inputs are quasi-static relative to the clock.
 */
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg;

	// At least one bit to carry
	if (WIDTH < 1) $error("WIDTH must be at least 1");

	// First stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= '1;
			dout     <= '1;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule
`default_nettype wire

//--- tb/audio_ctl_checker.sv
/*
 * Concurrent checks on the two-wire link between the master and audio ends.
 * Assumes QUARTER matches the master instance and one clock domain.
 */
`default_nettype none
module audio_ctl_checker #(
	parameter int QUARTER = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ==========================================================
	// Helper: cycles since the last clock rise, saturating
	logic       scl_prev;
	logic [7:0] run_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_prev <= 1'b1;
			run_cnt  <= 8'hff;
		end else begin
			scl_prev <= scl;
			if (scl && !scl_prev)
				run_cnt <= 8'h1;
			else if (run_cnt < 8'hfe)
				run_cnt <= run_cnt + 8'h1;
		end
	end

	// ==========================================================
	// Assertions
	a_dev_change_low: assert property (
		$changed(dev_sda_oe) |-> !scl && !$past(scl)
	) else $error("Audio end changed data with clock high");
	a_host_hold_high: assert property (
		$rose(scl) |=> $stable(host_sda_oe) [*3]
	) else $error("Master changed data with clock high");
	a_start_by_host: assert property (
		scl && $past(scl) && $fell(sda) |-> host_sda_oe
	) else $error("Start edge not made by master");
	a_stop_ends: assert property (
		scl && $past(scl) && $rose(sda) |=> (!dev_sda_oe) [*8]
	) else $error("Audio end drove data after stop");
	a_ack_whole: assert property (
		dev_sda_oe && $rose(scl) |-> dev_sda_oe [*8]
	) else $error("Acknowledge not held through clock high");
	a_ack_in_time: assert property (
		$rose(dev_sda_oe) |-> dev_sda_oe throughout (##[1:40] $rose(scl))
	) else $error("Acknowledge dropped before its clock pulse");
	a_ack_span: assert property (
		$rose(dev_sda_oe) |-> ##[14:18] $fell(dev_sda_oe)
	) else $error("Acknowledge not one bit period long");
	a_host_release: assert property (
		dev_sda_oe && scl |-> !host_sda_oe
	) else $error("Master drove data during acknowledge");
	a_bit_period: assert property (
		scl && !scl_prev && run_cnt != 8'hff |-> run_cnt >= 8'(4 * QUARTER)
	) else $error("Clock rises sooner than one bit period");
endmodule
`default_nettype wire

//--- tb/test_audio_processor_i2c_control.sv
/*
 * Bench: master end commanded over AXI4-Lite drives the audio end.
 * Assumes package, interface and design files are compiled first.
 */
`default_nettype none
module test_audio_processor_i2c_control;
	timeunit 1ns;
	timeprecision 1ns;
	import audio_ctl_pkg::*;
	localparam int Q = 4;
	localparam logic [2:0] SRC_TAB [4] = '{3'h0, 3'h2, 3'h1, 3'h4};
	typedef struct packed {
		logic [6:0] att_l;
		logic       mute_l;
		logic [6:0] att_r;
		logic       mute_r;
		logic [3:0] sm_loud;
		logic [2:0] src;
		logic       ch_l;
		logic       ch_r;
	} view_type;

	// ==========================================================
	// Signals and instances
	logic        aclk, aresetn, addr_pin_open;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp;
	logic [8:0]  wire_bits;
	wire view_type got;
	view_type    want;
	int          num_errors, checks_done;
	two_wire_if link ();
	audio_ctl_host #(.QUARTER(Q)) audio_ctl_host_i (
		.aclk(aclk), .aresetn(aresetn), .link(link.host),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);
	audio_ctl_device audio_ctl_device_i (
		.aclk(aclk), .aresetn(aresetn), .link(link.dev), .addr_pin_open(addr_pin_open),
		.att_left(got.att_l), .mute_left(got.mute_l), .att_right(got.att_r),
		.mute_right(got.mute_r), .soft_mute_on(got.sm_loud[3]),
		.soft_mute_fast(got.sm_loud[2]), .loud_on(got.sm_loud[1]),
		.loud_20db(got.sm_loud[0]), .source_input_a(got.src[2]),
		.source_input_b(got.src[1]), .source_input_c(got.src[0]),
		.chan_left_en(got.ch_l), .chan_right_en(got.ch_r)
	);
	audio_ctl_checker #(.QUARTER(Q)) audio_ctl_checker_i (
		.aclk(aclk), .aresetn(aresetn), .scl(link.scl), .sda(link.sda),
		.host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe)
	);

	// Clock and wire bit capture at each link clock rise
	initial aclk = 1'b0;
	always #5 aclk = ~aclk;
	always @(posedge link.scl) wire_bits <= {wire_bits[7:0], link.sda};

	// ==========================================================
	// Tasks
	task automatic check_word(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t word %h expected %h", $time, g, e);
		end
	endtask
	task automatic check_view(input view_type g, input view_type e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %0t settings %h expected %h", $time, g, e);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wait_idle();
		logic [31:0] d;
		logic [1:0]  r;
		d = 32'h1;
		while (d[ST_BUSY] !== 1'b0)
			axi_rd(REG_STATUS, d, r);
	endtask
	task automatic send(input logic [7:0] b, input logic st, input logic sp);
		logic [31:0] d;
		logic [1:0]  r;
		d = {22'h0, sp, st, b};
		axi_wr(REG_CMD, d, r);
		wait_idle();
	endtask
	// Send one byte, compare settings and, without stop, the nine wire bits
	task automatic step(input logic [7:0] b, input logic st, input logic sp, input logic nak);
		send(b, st, sp);
		check_view(got, want);
		if (!sp)
			check_word({23'h0, wire_bits}, {23'h0, b, nak});
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		#400_000;
		num_errors++;
		$display("MISMATCH %0t watchdog expired", $time);
		end_of_test();
	end

	// ==========================================================
	// Tests
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		addr_pin_open = 1'b1;
		wstrb = 4'hf;
		num_errors = 0;
		checks_done = 0;
		want = '{7'h7e, 1'b1, 7'h7e, 1'b1, 4'h1, 3'h1, 1'b1, 1'b1};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		check_view(got, want);
		$display("test reset done");
		step(ADDR_PIN_OPEN, 1'b1, 1'b0, 1'b0);
		want.ch_l = 1'b0;
		step(8'hc0, 1'b0, 1'b0, 1'b0);
		want.att_r = 7'd11;
		want.mute_r = 1'b0;
		step(8'h0b, 1'b0, 1'b0, 1'b0);
		want.ch_l = 1'b1;
		want.ch_r = 1'b0;
		step(8'hdd, 1'b0, 1'b0, 1'b0);
		want.att_l = 7'd88;
		want.mute_l = 1'b0;
		step(8'h58, 1'b0, 1'b0, 1'b0);
		want.ch_r = 1'b1;
		step(8'hc2, 1'b0, 1'b0, 1'b0);
		step(8'hdf, 1'b0, 1'b0, 1'b0);
		want = '{7'd103, 1'b1, 7'd103, 1'b1, want.sm_loud, want.src, 1'b1, 1'b1};
		step(8'h67, 1'b0, 1'b0, 1'b0);
		want.sm_loud = 4'ha;
		step(8'h80, 1'b0, 1'b0, 1'b0);
		want.sm_loud = 4'hf;
		step(8'h99, 1'b0, 1'b0, 1'b0);
		want.sm_loud = 4'h5;
		step(8'h9f, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			want.src = SRC_TAB[i];
			step(8'hbc | 8'(i), 1'b0, i == 3, 1'b0);
		end
		check_word({30'h0, link.scl, link.sda}, 32'h3);
		$display("test decode done");
		axi_rd(4'hc, d, r);
		check_word({d[29:0], r}, {30'h0, RESP_SLVERR});
		axi_wr(REG_CTRL, 32'h1, r);
		axi_rd(REG_CTRL, d, r);
		check_word(d, 32'h1);
		addr_pin_open <= 1'b0;
		send(ADDR_PIN_OPEN, 1'b1, 1'b0);
		axi_rd(REG_STATUS, d, r);
		check_word(d, 32'h6);
		axi_wr(REG_CTRL, 32'h0, r);
		step(ADDR_PIN_OPEN, 1'b1, 1'b0, 1'b1);
		step(8'h00, 1'b0, 1'b0, 1'b1);
		axi_rd(REG_STATUS, d, r);
		check_word(d, 32'h2);
		step(8'h00, 1'b0, 1'b1, 1'b1);
		step(ADDR_PIN_GND, 1'b1, 1'b0, 1'b0);
		axi_wr(REG_CMD, 32'hc1, r);
		axi_wr(REG_CMD, 32'h0, r);
		check_word({30'h0, r}, {30'h0, RESP_SLVERR});
		wait_idle();
		want.ch_r = 1'b0;
		check_view(got, want);
		want.att_l = 7'd0;
		want.mute_l = 1'b0;
		step(8'h00, 1'b0, 1'b1, 1'b0);
		$display("test address and refusal done");
		end_of_test();
	end
endmodule
`default_nettype wire
